// File: common/phy_gpio_wait_config_regs.vh
/*
 * register offsets, field positions, reset values and sizes for the
 * transceiver, port pull and wait-state register bank.
 * assumes the includer uses 8-bit special function register offsets.
 */
`ifndef PHY_GPIO_WAIT_CONFIG_REGS_VH
`define PHY_GPIO_WAIT_CONFIG_REGS_VH

// special function register offsets
`define INT_WAIT_ADDR     8'h9C
`define EXT_WAIT_LO_ADDR  8'h9D
`define EXT_WAIT_HI_ADDR  8'h9E
`define LATCH_DLY_ADDR    8'h9F
`define PULLDN_BASE_ADDR  8'hE3
`define PULLDN_LAST_ADDR  8'hE6
`define PULLUP_BASE_ADDR  8'hEB
`define PULLUP_LAST_ADDR  8'hEE
`define XCVR_SETUP_ADDR   8'hFE

// transceiver setup fields
`define XCVR_RESET_BIT    5
`define XCVR_PWDN_BIT     4
`define XCVR_MODE_EN_BIT  3
`define XCVR_MODE_MSB     2
`define XCVR_MODE_LSB     0
`define XCVR_USED_MASK    8'h3F

// internal wait-state fields
`define IWS_FLASH_LSB     0
`define IWS_FLASH_MSB     2
`define IWS_CORE_LSB      3
`define IWS_CORE_MSB      5
`define IWS_RAM_LSB       6
`define IWS_RAM_MSB       7

// reset values
`define XCVR_SETUP_RST    8'h00
`define PULL_RST          8'h00
`define WAIT_RST          8'h00
`define EXT_WAIT_RST      16'h0000
`define LATCH_DLY_RST     8'h00

// memory sizes
`define UDF_DEPTH         255
`define INT_RAM_LIMIT     24'h010000
`define EXT_ADDR_WIDTH    24

`endif

// File: src/sync2.v
/*
 * two-stage synchroniser for a group of level inputs.
 * assumes the inputs change slowly compared to clk.
 */
`timescale 1ns/1ps
module sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // levels
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1_r;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_r <= {WIDTH{1'b0}};
            dout     <= {WIDTH{1'b0}};
        end else begin
            stage1_r <= din;
            dout     <= stage1_r;
        end
    end
endmodule

// File: src/udf_mem.v
/*
 * small user data flash store with registered read data.
 * assumes one access per cycle; addresses at or above DEPTH are refused.
 */
`timescale 1ns/1ps
module udf_mem #(
    parameter DEPTH = 255,
    parameter AW    = 8,
    parameter DW    = 8
) (
    // clock and reset
    input  wire          clk,
    input  wire          reset,
    // access port
    input  wire [AW-1:0] addr,
    input  wire          wrEn,
    input  wire [DW-1:0] wrData,
    input  wire          rdEn,
    output reg  [DW-1:0] rdData,
    output reg           rdValid,
    output reg           accErr
);
    reg  [DW-1:0] mem [0:DEPTH-1];
    wire          inRange;

    assign inRange = ({1'b0, addr} < DEPTH[AW:0]);

    // storage itself has no reset, like a real flash array
    always @(posedge clk) begin
        if (wrEn && inRange) begin
            mem[addr] <= wrData;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData  <= {DW{1'b0}};
            rdValid <= 1'b0;
            accErr  <= 1'b0;
        end else begin
            rdValid <= rdEn && inRange;
            accErr  <= (rdEn || wrEn) && !inRange;
            if (rdEn && inRange) begin
                rdData <= mem[addr];
            end
        end
    end
endmodule

// File: src/phy_gpio_wait_config_regs.v
/*
 * special function register bank: transceiver setup, port pull-up and
 * pull-down, internal and external wait states, latch strobe delay,
 * memory lock gate, data address decode and user data flash.
 * assumes an 8-bit register port on the core clock with one-cycle
 * strobes; straps and lock levels arrive from pins.
 */
`timescale 1ns/1ps
`include "phy_gpio_wait_config_regs.vh"

module phy_gpio_wait_config_regs #(
    parameter LARGE_PKG = 1
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // register port
    input  wire [7:0]  sfrAddr,
    input  wire        sfrWrEn,
    input  wire [7:0]  sfrWrData,
    input  wire        sfrRdEn,
    output reg  [7:0]  sfrRdData,
    // pins
    input  wire [2:0]  modeStrap,
    input  wire        codeLockPin,
    input  wire        dataLockPin,
    // transceiver control
    output reg  [2:0]  xcvrMode,
    output reg         xcvrResetOut,
    output reg         xcvrPowerDown,
    // network traffic
    input  wire        netTxValidIn,
    input  wire [7:0]  netTxDataIn,
    input  wire        netRxValidIn,
    input  wire [7:0]  netRxDataIn,
    output reg         netTxValid,
    output reg  [7:0]  netTxData,
    output reg         netRxValid,
    output reg  [7:0]  netRxData,
    // port pulls
    output reg  [31:0] pullUpEn,
    output reg  [31:0] pullDownEn,
    // wait states
    output reg  [1:0]  ramWaitStates,
    output reg  [2:0]  coreWaitStates,
    output reg  [2:0]  flashWaitStates,
    // data memory access
    input  wire        dataReq,
    input  wire [23:0] dataAddr,
    output reg         intRamSel,
    output reg         extBusy,
    output reg         aleStrobe,
    output reg         extAccessDone,
    output reg  [23:0] extAddr,
    // external read-out
    input  wire        dumpReq,
    input  wire        dumpIsCode,
    output reg         dumpGrant,
    output reg         dumpDeny,
    // user data flash
    input  wire [7:0]  udfAddr,
    input  wire        udfWrEn,
    input  wire [7:0]  udfWrData,
    input  wire        udfRdEn,
    output wire [7:0]  udfRdData,
    output wire        udfRdValid,
    output wire        udfError
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_DLY  = 5'h02;
    localparam [4:0] ST_ALE  = 5'h04;
    localparam [4:0] ST_WAIT = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    reg  [7:0]  setup_r;
    reg  [7:0]  intWait_r;
    reg  [15:0] extWait_r;
    reg  [7:0]  latchDly_r;
    reg  [31:0] pullUp_r;
    reg  [31:0] pullDown_r;
    reg  [2:0]  appliedMode_r;
    reg  [4:0]  state_r;
    reg  [4:0]  state_nxt;
    reg  [15:0] count_r;
    reg  [15:0] count_nxt;
    reg  [23:0] addrHold_r;
    reg  [7:0]  rdMux;
    wire [2:0]  modeSync;
    wire [1:0]  lockSync;
    wire        resetFall;
    wire        pwdn;
    wire        isPullUp;
    wire        isPullDown;
    wire [1:0]  pullIdx;
    wire        extReq;

    // pins cross into the core clock before anything looks at them
    sync2 #(
        .WIDTH (5)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({modeStrap, codeLockPin, dataLockPin}),
        .dout  ({modeSync, lockSync})
    );

    // user data flash: 255 bytes, the last address is refused
    udf_mem #(
        .DEPTH  (`UDF_DEPTH),
        .AW     (8),
        .DW     (8)
    ) u_udf (
        .clk    (clk),
        .reset  (reset),
        .addr   (udfAddr),
        .wrEn   (udfWrEn),
        .wrData (udfWrData),
        .rdEn   (udfRdEn),
        .rdData (udfRdData),
        .rdValid(udfRdValid),
        .accErr (udfError)
    );

    assign pwdn       = setup_r[`XCVR_PWDN_BIT];
    assign isPullUp   = (sfrAddr >= `PULLUP_BASE_ADDR) &&
                        (sfrAddr <= `PULLUP_LAST_ADDR);
    assign isPullDown = (sfrAddr >= `PULLDN_BASE_ADDR) &&
                        (sfrAddr <= `PULLDN_LAST_ADDR);
    assign pullIdx    = isPullUp ? sfrAddr[1:0] - 2'h3 : sfrAddr[1:0] - 2'h3;
    // a write of setup that clears the reset bit while it was set
    assign resetFall  = sfrWrEn && (sfrAddr == `XCVR_SETUP_ADDR) &&
                        setup_r[`XCVR_RESET_BIT] &&
                        !sfrWrData[`XCVR_RESET_BIT];
    assign extReq     = dataReq && (LARGE_PKG != 0) &&
                        (dataAddr >= `INT_RAM_LIMIT);

    // register writes; none of them depend on power-down
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            setup_r    <= `XCVR_SETUP_RST;
            intWait_r  <= `WAIT_RST;
            extWait_r  <= `EXT_WAIT_RST;
            latchDly_r <= `LATCH_DLY_RST;
            pullUp_r   <= {4{`PULL_RST}};
            pullDown_r <= {4{`PULL_RST}};
        end else if (sfrWrEn) begin
            case (sfrAddr)
                `XCVR_SETUP_ADDR: begin
                    setup_r <= sfrWrData & `XCVR_USED_MASK;
                end
                `INT_WAIT_ADDR: begin
                    intWait_r <= sfrWrData;
                end
                `EXT_WAIT_LO_ADDR: begin
                    extWait_r[7:0] <= sfrWrData;
                end
                `EXT_WAIT_HI_ADDR: begin
                    extWait_r[15:8] <= sfrWrData;
                end
                `LATCH_DLY_ADDR: begin
                    latchDly_r <= sfrWrData;
                end
                default: begin
                    // only the addressed byte lane changes
                    if (isPullUp) begin
                        case (pullIdx)
                            2'h0: pullUp_r[7:0]   <= sfrWrData;
                            2'h1: pullUp_r[15:8]  <= sfrWrData;
                            2'h2: pullUp_r[23:16] <= sfrWrData;
                            default: pullUp_r[31:24] <= sfrWrData;
                        endcase
                    end else if (isPullDown) begin
                        case (pullIdx)
                            2'h0: pullDown_r[7:0]   <= sfrWrData;
                            2'h1: pullDown_r[15:8]  <= sfrWrData;
                            2'h2: pullDown_r[23:16] <= sfrWrData;
                            default: pullDown_r[31:24] <= sfrWrData;
                        endcase
                    end
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        rdMux = 8'h00;
        if (isPullUp) begin
            case (pullIdx)
                2'h0: rdMux = pullUp_r[7:0];
                2'h1: rdMux = pullUp_r[15:8];
                2'h2: rdMux = pullUp_r[23:16];
                default: rdMux = pullUp_r[31:24];
            endcase
        end else if (isPullDown) begin
            case (pullIdx)
                2'h0: rdMux = pullDown_r[7:0];
                2'h1: rdMux = pullDown_r[15:8];
                2'h2: rdMux = pullDown_r[23:16];
                default: rdMux = pullDown_r[31:24];
            endcase
        end else begin
            case (sfrAddr)
                `XCVR_SETUP_ADDR:  rdMux = setup_r & `XCVR_USED_MASK;
                `INT_WAIT_ADDR:    rdMux = intWait_r;
                `EXT_WAIT_LO_ADDR: rdMux = extWait_r[7:0];
                `EXT_WAIT_HI_ADDR: rdMux = extWait_r[15:8];
                `LATCH_DLY_ADDR:   rdMux = latchDly_r;
                default:           rdMux = 8'h00;
            endcase
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sfrRdData <= 8'h00;
        end else if (sfrRdEn) begin
            sfrRdData <= rdMux;
        end
    end

    // the mode is applied when software ends the reset pulse, so a
    // half-written mode never reaches the transceiver
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            appliedMode_r <= 3'h0;
        end else if (resetFall) begin
            if (setup_r[`XCVR_MODE_EN_BIT]) begin
                appliedMode_r <= setup_r[`XCVR_MODE_MSB:`XCVR_MODE_LSB];
            end else begin
                appliedMode_r <= modeSync;
            end
        end
    end

    // transceiver control and pin outputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            xcvrMode        <= 3'h0;
            xcvrResetOut    <= 1'b0;
            xcvrPowerDown   <= 1'b0;
            pullUpEn        <= 32'h0000_0000;
            pullDownEn      <= 32'h0000_0000;
            ramWaitStates   <= 2'h0;
            coreWaitStates  <= 3'h0;
            flashWaitStates <= 3'h0;
        end else begin
            xcvrMode        <= appliedMode_r;
            xcvrResetOut    <= setup_r[`XCVR_RESET_BIT];
            xcvrPowerDown   <= pwdn;
            pullUpEn        <= pullUp_r;
            pullDownEn      <= pullDown_r;
            ramWaitStates   <= intWait_r[`IWS_RAM_MSB:`IWS_RAM_LSB];
            coreWaitStates  <= intWait_r[`IWS_CORE_MSB:`IWS_CORE_LSB];
            flashWaitStates <= intWait_r[`IWS_FLASH_MSB:`IWS_FLASH_LSB];
        end
    end

    // network traffic stops both ways while powered down; no queueing,
    // so frames offered during power-down are simply dropped
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            netTxValid <= 1'b0;
            netTxData  <= 8'h00;
            netRxValid <= 1'b0;
            netRxData  <= 8'h00;
        end else begin
            netTxValid <= netTxValidIn && !pwdn;
            netRxValid <= netRxValidIn && !pwdn;
            netTxData  <= pwdn ? 8'h00 : netTxDataIn;
            netRxData  <= pwdn ? 8'h00 : netRxDataIn;
        end
    end

    // external read-out gate; lock levels only come from the pins, so
    // software cannot lift a lock
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dumpGrant <= 1'b0;
            dumpDeny  <= 1'b0;
        end else begin
            dumpGrant <= dumpReq &&
                         !(dumpIsCode ? lockSync[1] : lockSync[0]);
            dumpDeny  <= dumpReq &&
                         (dumpIsCode ? lockSync[1] : lockSync[0]);
        end
    end

    // external data access sequencer: strobe delay, strobe, waits
    always @* begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            ST_IDLE: begin
                if (extReq) begin
                    count_nxt = {8'h00, latchDly_r};
                    state_nxt = (latchDly_r == 8'h00) ? ST_ALE : ST_DLY;
                end
            end
            ST_DLY: begin
                count_nxt = count_r - 16'h0001;
                if (count_r == 16'h0001) begin
                    state_nxt = ST_ALE;
                end
            end
            ST_ALE: begin
                count_nxt = extWait_r;
                state_nxt = (extWait_r == 16'h0000) ? ST_DONE : ST_WAIT;
            end
            ST_WAIT: begin
                count_nxt = count_r - 16'h0001;
                if (count_r == 16'h0001) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
                count_nxt = 16'h0000;
            end
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            count_r    <= 16'h0000;
            addrHold_r <= 24'h000000;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            if (state_r == ST_IDLE && extReq) begin
                addrHold_r <= dataAddr;
            end
        end
    end

    // decode: low 64 Kbyte is internal, the rest of 16 Mbyte external
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            intRamSel     <= 1'b0;
            extBusy       <= 1'b0;
            aleStrobe     <= 1'b0;
            extAccessDone <= 1'b0;
            extAddr       <= 24'h000000;
        end else begin
            intRamSel     <= dataReq &&
                             (dataAddr < `INT_RAM_LIMIT);
            extBusy       <= (state_nxt != ST_IDLE);
            aleStrobe     <= (state_nxt == ST_ALE);
            extAccessDone <= (state_nxt == ST_DONE);
            extAddr       <= (state_r == ST_IDLE) ? dataAddr : addrHold_r;
        end
    end
endmodule

// File: dv/phy_gpio_wait_config_regs_checker.sv
/*
 * concurrent checks on the register bank ports.
 * assumes it is bound to phy_gpio_wait_config_regs, one clock domain.
 */
`timescale 1ns/1ps
module phy_gpio_wait_config_regs_checker (
    // clock and reset
    input wire        clk,
    input wire        reset,
    // register port
    input wire [7:0]  sfrAddr,
    input wire        sfrWrEn,
    input wire [7:0]  sfrWrData,
    input wire        sfrRdEn,
    input wire [7:0]  sfrRdData,
    // transceiver and traffic
    input wire        xcvrResetOut,
    input wire        xcvrPowerDown,
    input wire [2:0]  xcvrMode,
    input wire        netTxValidIn,
    input wire [7:0]  netTxDataIn,
    input wire        netTxValid,
    input wire [7:0]  netTxData,
    input wire        netRxValid,
    // pulls
    input wire [31:0] pullUpEn,
    input wire [31:0] pullDownEn,
    // data memory and read-out
    input wire        dataReq,
    input wire [23:0] dataAddr,
    input wire        intRamSel,
    input wire        extBusy,
    input wire        extAccessDone,
    input wire [23:0] extAddr,
    input wire        codeLockPin,
    input wire        dumpReq,
    input wire        dumpIsCode,
    input wire        dumpGrant,
    input wire        dumpDeny
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire wrSetup = sfrWrEn && sfrAddr == 8'hFE;
    wire wrPd0   = sfrWrEn && sfrAddr == 8'hE3;
    wire wrPu3   = sfrWrEn && sfrAddr == 8'hEE;
    sequence s_setup_once;
        wrSetup ##1 !wrSetup;
    endsequence
    // lock pin is synchronised, so it must have been steady a while
    sequence s_code_locked;
        codeLockPin [*4] ##0 dumpReq && dumpIsCode;
    endsequence
    property p_setup_ctrl;
        s_setup_once |=> xcvrResetOut == $past(sfrWrData[5], 2)
            && xcvrPowerDown == $past(sfrWrData[4], 2);
    endproperty
    a_setup_ctrl: assert property (p_setup_ctrl)
        else $error("setup control outputs wrong");
    property p_unused;
        sfrRdEn && sfrAddr == 8'hFE |=> sfrRdData[7:6] == 2'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("setup upper bits not zero");
    property p_mode;
        wrSetup && xcvrResetOut && !sfrWrData[5] && sfrWrData[3]
            |-> ##2 xcvrMode == $past(sfrWrData[2:0], 2);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode not applied on reset release");
    property p_gate;
        xcvrPowerDown |-> !netTxValid && !netRxValid;
    endproperty
    a_gate: assert property (p_gate)
        else $error("traffic passed in power-down");
    property p_pass;
        !xcvrPowerDown |-> netTxValid == $past(netTxValidIn)
            && netTxData == $past(netTxDataIn);
    endproperty
    a_pass: assert property (p_pass)
        else $error("traffic lost outside power-down");
    property p_pd_access;
        xcvrPowerDown && !$past(wrSetup) && sfrRdEn && sfrAddr == 8'hFE
            |=> sfrRdData[4];
    endproperty
    a_pd_access: assert property (p_pd_access)
        else $error("register read wrong in power-down");
    property p_pulldown;
        wrPd0 ##1 !wrPd0 |=> pullDownEn[7:0] == $past(sfrWrData, 2);
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("port 0 pull-down not applied");
    property p_pullup;
        wrPu3 ##1 !wrPu3 |=> pullUpEn[31:24] == $past(sfrWrData, 2);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("port 3 pull-up not applied");
    property p_deny;
        s_code_locked |=> dumpDeny && !dumpGrant;
    endproperty
    a_deny: assert property (p_deny)
        else $error("locked code read-out granted");
    property p_ext_start;
        dataReq && dataAddr >= 24'h010000 && !extBusy
            |=> extBusy && extAddr == $past(dataAddr);
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("external access not started");
    property p_int_sel;
        dataReq && dataAddr < 24'h010000 |=> intRamSel && !extAccessDone;
    endproperty
    a_int_sel: assert property (p_int_sel)
        else $error("internal data access not selected");
endmodule

bind phy_gpio_wait_config_regs phy_gpio_wait_config_regs_checker u_chk (.*);

// File: dv/testbench.sv
/*
 * self-checking bench for the register bank, one task per scenario.
 * assumes inputs change at the falling edge, design samples rising.
 */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset, sfrWrEn, sfrRdEn, codeLockPin, dataLockPin, netTxValidIn;
    logic netRxValidIn, dataReq, dumpReq, dumpIsCode, udfWrEn, udfRdEn;
    logic [7:0] sfrAddr, sfrWrData, netTxDataIn, netRxDataIn;
    logic [7:0] udfAddr, udfWrData;
    logic [2:0] modeStrap;
    logic [23:0] dataAddr;
    wire [7:0] sfrRdData, netTxData, netRxData, udfRdData;
    wire [2:0] xcvrMode, coreWaitStates, flashWaitStates;
    wire [1:0] ramWaitStates;
    wire [31:0] pullUpEn, pullDownEn;
    wire [23:0] extAddr;
    wire xcvrResetOut, xcvrPowerDown, netTxValid, netRxValid, intRamSel;
    wire extBusy, aleStrobe, extAccessDone, dumpGrant, dumpDeny;
    wire udfRdValid, udfError;
    int err_total = 0;
    int checked = 0;

    phy_gpio_wait_config_regs u_phy_gpio_wait_config_regs (.*);

    always #4 clk = ~clk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                       input string msg);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s: %0h not %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        cyc(1);
        sfrWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(1);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        cyc(1);
        sfrRdEn = 1'b0;
        d = sfrRdData;
    endtask
    // traffic is always offered, so power-down has something to drop
    task automatic net(input logic pd);
        {netTxValidIn, netRxValidIn} = 2'h3;
        {netTxDataIn, netRxDataIn} = {8'hA5, 8'h3C};
        cyc(1);
        {netTxValidIn, netRxValidIn} = 2'h0;
        chk({netTxValid, netRxValid}, {!pd, !pd}, "traffic valid");
        chk({netTxData, netRxData}, pd ? 16'h0 : 16'hA53C, "data");
    endtask
    task automatic dump(input logic isCode, input logic deny);
        cyc(1);
        {dumpReq, dumpIsCode} = {1'b1, isCode};
        cyc(1);
        dumpReq = 1'b0;
        chk({dumpDeny, dumpGrant}, {deny, !deny}, "read-out");
    endtask
    task automatic uacc(input logic [7:0] a, input logic we,
                        input logic [7:0] d);
        cyc(1);
        {udfAddr, udfWrData, udfWrEn, udfRdEn} = {a, d, we, !we};
        cyc(1);
        {udfWrEn, udfRdEn} = 2'h0;
    endtask

    task automatic t_regs;
        logic [7:0] d;
        rd(8'hFE, d);
        chk(d, 8'h00, "setup reset");
        chk({pullUpEn, pullDownEn}, 64'h0, "pull reset");
        wr(8'hFE, 8'hFF);
        rd(8'hFE, d);
        chk(d, 8'h3F, "setup unused bits");
        chk({xcvrResetOut, xcvrPowerDown}, 2'h3, "setup outs");
        wr(8'h9C, 8'hB5);
        wr(8'h9D, 8'h34);
        wr(8'h9E, 8'h12);
        wr(8'h9F, 8'h56);
        rd(8'h9C, d);
        chk(d, 8'hB5, "int wait");
        chk({ramWaitStates, coreWaitStates, flashWaitStates}, 8'hB5,
            "wait fields");
        rd(8'h9D, d);
        chk(d, 8'h34, "ext wait lo");
        rd(8'h9E, d);
        chk(d, 8'h12, "ext wait hi");
        rd(8'h9F, d);
        chk(d, 8'h56, "ale delay");
        // leave setup clear so the reset pulse applies the strap mode
        wr(8'hFE, 8'h20);
        wr(8'hFE, 8'h00);
        cyc(2);
        chk(xcvrMode, 3'h0, "mode after setup clear");
        $display("test regs finished");
    endtask
    task automatic t_mode;
        modeStrap = 3'h5;
        wr(8'hFE, 8'h0B);
        cyc(3);
        chk(xcvrMode, 3'h0, "mode early");
        wr(8'hFE, 8'h2B);
        cyc(1);
        chk(xcvrResetOut, 1'b1, "xcvr reset");
        cyc(3);
        wr(8'hFE, 8'h0B);
        cyc(2);
        chk(xcvrMode, 3'h3, "mode reg");
        wr(8'hFE, 8'h20);
        cyc(4);
        wr(8'hFE, 8'h00);
        cyc(2);
        chk(xcvrMode, 3'h5, "mode pins");
        $display("test mode finished");
    endtask
    task automatic t_pd;
        logic [7:0] d;
        wr(8'hFE, 8'h10);
        cyc(1);
        chk(xcvrPowerDown, 1'b1, "pd out");
        net(1'b1);
        rd(8'hFE, d);
        chk(d, 8'h10, "pd read");
        wr(8'hFE, 8'h00);
        cyc(1);
        net(1'b0);
        $display("test power-down finished");
    endtask
    task automatic t_pull;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(8'hE3 + 8'(i), 8'hA0 + 8'(i));
            wr(8'hEB + 8'(i), 8'h50 + 8'(i));
        end
        wr(8'hE5, 8'hA3);
        wr(8'hE7, 8'hFF);
        wr(8'hEA, 8'hFF);
        cyc(1);
        chk(pullDownEn, 32'hA3A3A1A0, "pull-down");
        chk(pullUpEn, 32'h53525150, "pull-up");
        rd(8'hE6, d);
        chk(d, 8'hA3, "pull-down read");
        rd(8'hEB, d);
        chk(d, 8'h50, "pull-up read");
        rd(8'hE7, d);
        chk(d, 8'h00, "unmapped");
        $display("test pull finished");
    endtask
    task automatic t_ext;
        wr(8'h9F, 8'h00);
        wr(8'h9D, 8'h01);
        wr(8'h9E, 8'h00);
        cyc(2);
        {dataReq, dataAddr} = {1'b1, 24'h00FFFF};
        cyc(1);
        dataReq = 1'b0;
        chk({intRamSel, extBusy}, 2'h2, "internal ram");
        cyc(1);
        {dataReq, dataAddr} = {1'b1, 24'h012345};
        cyc(1);
        dataAddr = 24'h020000;
        chk({extBusy, aleStrobe}, 2'h3, "ale");
        cyc(1);
        dataReq = 1'b0;
        chk({aleStrobe, extAccessDone}, 2'h0, "ale end");
        cyc(1);
        chk({extAccessDone, extAddr}, 25'h1012345, "done");
        cyc(1);
        chk({extBusy, extAccessDone}, 2'h0, "idle");
        cyc(1);
        chk(extBusy, 1'b0, "busy request ignored");
        $display("test external finished");
    endtask
    task automatic t_lock;
        {codeLockPin, dataLockPin} = 2'h2;
        cyc(3);
        dump(1'b1, 1'b1);
        dump(1'b0, 1'b0);
        {codeLockPin, dataLockPin} = 2'h1;
        cyc(3);
        dump(1'b1, 1'b0);
        dump(1'b0, 1'b1);
        uacc(8'hFE, 1'b1, 8'h5A);
        chk(udfError, 1'b0, "flash write");
        uacc(8'hFE, 1'b0, 8'h00);
        chk({udfRdValid, udfError, udfRdData}, 10'h25A, "flash read");
        uacc(8'hFF, 1'b1, 8'h11);
        chk(udfError, 1'b1, "flash past end");
        $display("test lock and flash finished");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {sfrWrEn, sfrRdEn, codeLockPin, dataLockPin, netTxValidIn} = 5'h0;
        {netRxValidIn, dataReq, dumpReq, dumpIsCode, udfWrEn, udfRdEn} = 6'h0;
        {sfrAddr, sfrWrData, netTxDataIn, netRxDataIn} = 32'h0;
        {udfAddr, udfWrData, modeStrap, dataAddr} = 43'h0;
        cyc(4);
        reset = 1'b0;
        t_regs;
        t_mode;
        t_pd;
        t_pull;
        t_ext;
        t_lock;
        summarize;
    end

    // the scenarios need well under a thousand cycles
    initial begin
        #(5000 * 8);
        err_total++;
        summarize;
    end
endmodule
